// file: nib_core.sv
`timescale 1ns/1ps
`include "nib_regs.svh"
// Behaviour
// - Program counter is page bit over an 11-bit incrementing counter.
// - Counter steps by one unless jump, table jump, branch, call, return, interrupt or reset loads it.
// - Carry takes overflow, is pushed, restored by interrupt return only.
// - Accumulator is four bits and moves data to registers and memories.
// - Stack entries are 13 bits: carry on top, counter bits 10-0 below.
// - Stack is last-in first-out; fifth push drops the bottom entry.
// - Program store holds 2048 sixteen-bit words fetched by the counter.
// - Vectors: reset 0, external 1, timer A 2, timer B 3, port B 4.
// - Table jump goes to counter bits 11-8, table register, accumulator.
// - Constant return loads word bits 7-4 to table register, 3-0 to acc.
// - Registers below 20h, data 20h-11Fh, display nibbles 300h-319h.
// - Data and display locations are reached in one cycle and keep their contents.
// - Indirect window uses the 10-bit address from the three pointers.
// - Detector write-only code: 0101 enables, default; 1010 disables.
// - Bond readback gives two pin bits, upper bits read zero.
// - Control bit 0 puts port A pins 1 and 2 on alarm output.
// - Control bit 1 sets heavy-load oscillator mode, off after reset.
// - Control bit 2 turns the display off, on after reset.
// - Control bit 3 makes segments 1-4 general outputs, off after reset.
// - Envelope select zero is steady; bits 0-2 pick 1, 2, 4 Hz.
// - Timers show load and count as low and high nibble registers.
// - Duty bit set selects quarter duty with one-third bias.
// - Interrupt entry and reset clear all four enable flags.
// - Envelope write resyncs its counter; reading disturbs nothing.
module nib_core (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_prog_we,
  input  wire logic [10:0] i_prog_addr,
  input  wire logic [15:0] i_prog_data,
  input  wire logic [3:0]  i_irq_event,
  input  wire logic [3:0]  i_port_a,
  input  wire logic [3:0]  i_port_b,
  input  wire logic [3:0]  i_port_c,
  input  wire logic [3:0]  i_port_d,
  input  wire logic [1:0]  i_bond_pins,
  input  wire logic [7:0]  i_timer_a_count,
  input  wire logic [7:0]  i_timer_b_count,
  input  wire logic [4:0]  i_disp_addr,
  output logic      [11:0] o_pc,
  output logic      [3:0]  o_port_a,
  output logic      [3:0]  o_port_b,
  output logic      [3:0]  o_port_c,
  output logic      [3:0]  o_port_d,
  output logic      [2:0]  o_timer_a_mode,
  output logic      [2:0]  o_timer_b_mode,
  output logic      [7:0]  o_timer_a_load,
  output logic      [7:0]  o_timer_b_load,
  output logic             o_timer_a_reload,
  output logic             o_timer_b_reload,
  output logic             o_detector_enable,
  output logic             o_alarm_pin_select,
  output logic             o_heavy_load_osc,
  output logic             o_display_off,
  output logic             o_seg_as_port,
  output logic      [3:0]  o_alarm_envelope,
  output logic             o_envelope_resync,
  output logic             o_quarter_duty,
  output logic      [3:0]  o_disp_data
);
  typedef struct packed {
    logic [11:0] pc;
    logic [3:0]  acc;
    logic        cy;
    logic [3:0]  table_branch_upper;
    logic [3:0]  ie;
    logic [3:0]  irq;
    logic [2:0]  tam;
    logic [2:0]  tbm;
    logic [7:0]  ta_ld;
    logic [7:0]  tb_ld;
    logic [3:0]  ta_lat;
    logic [3:0]  tb_lat;
    logic        ta_rl;
    logic        tb_rl;
    logic [3:0]  pa;
    logic [3:0]  pb;
    logic [3:0]  pc_port;
    logic [3:0]  pd;
    logic        det_en;
    logic [3:0]  pointer_low;
    logic [2:0]  pointer_middle;
    logic [2:0]  pointer_high;
    logic [3:0]  ctl;
    logic [3:0]  aec;
    logic        resync;
    logic        duty;
  } nib_core_s;

  nib_core_s         q, d;
  logic [15:0]       rom [0:`NIB_ROM_WORDS-1];
  logic [15:0]       ins;
  nib_pkg::nib_op_e  op;
  logic [9:0]        daddr;
  logic [9:0]        ea;
  logic              is_ind;
  logic              is_sys;
  logic [3:0]        rd;
  logic [3:0]        sys_rd;
  logic              do_rd;
  logic              do_wr;
  logic [4:0]        sum;
  logic [3:0]        pend;
  logic [11:0]       pc_inc;
  logic [3:0]        irq_base;
  nib_stk_if         sif ();
  nib_mem_if         mif ();

  nib_stack u_stack (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .bus        (sif)
  );

  nib_dmem u_dmem (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .bus        (mif)
  );

  always_ff @(posedge i_core_clk)
  begin
    if (i_prog_we)
      rom[i_prog_addr] <= i_prog_data;
  end

  always_comb
  begin
    d          = q;
    d.ta_rl    = 1'b0;
    d.tb_rl    = 1'b0;
    d.resync   = 1'b0;
    irq_base   = q.irq;
    sum        = '0;
    sif.push   = 1'b0;
    sif.pop    = 1'b0;
    sif.wdata  = '0;
    ins        = rom[q.pc[10:0]];
    op         = nib_pkg::nib_op_e'(ins[15:12]);
    daddr      = ins[9:0];
    pc_inc     = {q.pc[11], 11'(q.pc[10:0] + 11'h001)};
    is_ind     = (daddr == {5'h00, `NIB_OFS_IDX});
    ea         = is_ind ? {q.pointer_high, q.pointer_middle, q.pointer_low} : daddr;
    is_sys     = !is_ind && (ea < `NIB_SYS_END);
    pend       = q.ie & q.irq;
    do_rd      = (op == nib_pkg::NIB_LDA) || (op == nib_pkg::NIB_ADC) ||
                 (op == nib_pkg::NIB_AND);
    do_wr      = (op == nib_pkg::NIB_STA) && (pend == 4'h0);
    mif.addr   = ea;
    mif.wdata  = q.acc;
    mif.we     = do_wr && !is_sys;
    mif.disp_addr = i_disp_addr;

    // System register read mux, reserved and write-only read zero
    unique case (ea[4:0])
      `NIB_OFS_IE:   sys_rd = q.ie;
      `NIB_OFS_IRQ:  sys_rd = q.irq;
      `NIB_OFS_TAM:  sys_rd = {1'b0, q.tam};
      `NIB_OFS_TBM:  sys_rd = {1'b0, q.tbm};
      `NIB_OFS_TAL:  sys_rd = q.ta_lat;
      `NIB_OFS_TAH:  sys_rd = i_timer_a_count[7:4];
      `NIB_OFS_TBL:  sys_rd = q.tb_lat;
      `NIB_OFS_TBH:  sys_rd = i_timer_b_count[7:4];
      `NIB_OFS_PA:   sys_rd = i_port_a;
      `NIB_OFS_PB:   sys_rd = i_port_b;
      `NIB_OFS_PC:   sys_rd = i_port_c;
      `NIB_OFS_PD:   sys_rd = i_port_d;
      `NIB_OFS_BOND: sys_rd = {2'b00, i_bond_pins};
      `NIB_OFS_TBR:  sys_rd = q.table_branch_upper;
      `NIB_OFS_DPL:  sys_rd = q.pointer_low;
      `NIB_OFS_DPM:  sys_rd = {1'b0, q.pointer_middle};
      `NIB_OFS_DPH:  sys_rd = {1'b0, q.pointer_high};
      `NIB_OFS_CTL:  sys_rd = q.ctl;
      `NIB_OFS_AEC:  sys_rd = q.aec;
      `NIB_OFS_DUTY: sys_rd = {3'b000, q.duty};
      default:       sys_rd = 4'h0;
    endcase
    rd = is_sys ? sys_rd : mif.rdata;

    if (pend != 4'h0)
    begin
      // Interrupt entry replaces this cycle's instruction
      sif.push  = 1'b1;
      sif.wdata = {q.cy, 1'b0, q.pc[10:0]};
      d.ie      = 4'h0;
      if (pend[3])
        d.pc = `NIB_VEC_EXT;
      else if (pend[2])
        d.pc = `NIB_VEC_TA;
      else if (pend[1])
        d.pc = `NIB_VEC_TB;
      else
        d.pc = `NIB_VEC_PORTB;
    end
    else
    begin
      d.pc = pc_inc;
      unique case (op)
        nib_pkg::NIB_LDA:
          d.acc = rd;
        nib_pkg::NIB_ADC:
        begin
          sum   = {1'b0, q.acc} + {1'b0, rd} + {4'h0, q.cy};
          d.acc = sum[3:0];
          d.cy  = sum[4];
        end
        nib_pkg::NIB_ADI:
        begin
          sum   = {1'b0, q.acc} + {1'b0, ins[3:0]};
          d.acc = sum[3:0];
          d.cy  = sum[4];
        end
        nib_pkg::NIB_AND:
          d.acc = q.acc & rd;
        nib_pkg::NIB_JMP:
          d.pc = ins[11:0];
        nib_pkg::NIB_CALL:
        begin
          sif.push  = 1'b1;
          sif.wdata = {q.cy, 1'b0, pc_inc[10:0]};
          d.pc      = {q.pc[11], ins[10:0]};
        end
        nib_pkg::NIB_TABLE_BRANCH_JUMP:
          d.pc = {q.pc[11:8], q.table_branch_upper, q.acc};
        nib_pkg::NIB_RETURN_WITH_CONSTANT:
        begin
          sif.pop = 1'b1;
          d.table_branch_upper   = ins[7:4];
          d.acc   = ins[3:0];
          d.pc    = {q.pc[11], sif.top[10:0]};
        end
        nib_pkg::NIB_RETURN_FROM_INTERRUPT:
        begin
          sif.pop = 1'b1;
          d.cy    = sif.top[12];
          d.pc    = {q.pc[11], sif.top[10:0]};
        end
        nib_pkg::NIB_BC:
          if (q.cy)
            d.pc = {q.pc[11], ins[10:0]};
        default:
          d.pc = pc_inc;
      endcase
    end

    // Timer high read latches the low nibble for the following read
    if (do_rd && is_sys && (pend == 4'h0))
    begin
      if (ea[4:0] == `NIB_OFS_TAH)
        d.ta_lat = i_timer_a_count[3:0];
      if (ea[4:0] == `NIB_OFS_TBH)
        d.tb_lat = i_timer_b_count[3:0];
    end

    if (do_wr && is_sys)
    begin
      unique case (ea[4:0])
        `NIB_OFS_IE:   d.ie = q.acc;
        `NIB_OFS_IRQ:  irq_base = q.acc;
        `NIB_OFS_TAM:  d.tam = q.acc[2:0];
        `NIB_OFS_TBM:  d.tbm = q.acc[2:0];
        `NIB_OFS_TAL:  d.ta_ld[3:0] = q.acc;
        `NIB_OFS_TAH:
        begin
          d.ta_ld[7:4] = q.acc;
          d.ta_rl      = 1'b1;
        end
        `NIB_OFS_TBL:  d.tb_ld[3:0] = q.acc;
        `NIB_OFS_TBH:
        begin
          d.tb_ld[7:4] = q.acc;
          d.tb_rl      = 1'b1;
        end
        `NIB_OFS_PA:   d.pa = q.acc;
        `NIB_OFS_PB:   d.pb = q.acc;
        `NIB_OFS_PC:   d.pc_port = q.acc;
        `NIB_OFS_PD:   d.pd = q.acc;
        `NIB_OFS_DET:
          if (q.acc == `NIB_DET_ON)
            d.det_en = 1'b1;
          else if (q.acc == `NIB_DET_OFF)
            d.det_en = 1'b0;
        `NIB_OFS_TBR:  d.table_branch_upper = q.acc;
        `NIB_OFS_DPL:  d.pointer_low = q.acc;
        `NIB_OFS_DPM:  d.pointer_middle = q.acc[2:0];
        `NIB_OFS_DPH:  d.pointer_high = q.acc[2:0];
        `NIB_OFS_CTL:  d.ctl = q.acc;
        `NIB_OFS_AEC:
        begin
          d.aec    = q.acc;
          d.resync = 1'b1;
        end
        `NIB_OFS_DUTY: d.duty = q.acc[0];
        default:       d.duty = q.duty;
      endcase
    end

    // New request events win over a software clear in the same cycle
    d.irq = irq_base | i_irq_event;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      q        <= '0;
      q.pc     <= `NIB_VEC_RESET;
      q.ie     <= 4'h0;
      q.det_en <= 1'b1;
      q.ctl    <= `NIB_CTL_RST;
      q.aec    <= `NIB_AEC_RST;
    end
    else
      q <= d;
  end

  assign o_pc               = q.pc;
  assign o_port_a           = q.pa;
  assign o_port_b           = q.pb;
  assign o_port_c           = q.pc_port;
  assign o_port_d           = q.pd;
  assign o_timer_a_mode     = q.tam;
  assign o_timer_b_mode     = q.tbm;
  assign o_timer_a_load     = q.ta_ld;
  assign o_timer_b_load     = q.tb_ld;
  assign o_timer_a_reload   = q.ta_rl;
  assign o_timer_b_reload   = q.tb_rl;
  assign o_detector_enable  = q.det_en;
  assign o_alarm_pin_select = q.ctl[`NIB_CTL_PAM];
  assign o_heavy_load_osc   = q.ctl[`NIB_CTL_HLM];
  assign o_display_off      = q.ctl[`NIB_CTL_OFF];
  assign o_seg_as_port      = q.ctl[`NIB_CTL_OS];
  assign o_alarm_envelope   = q.aec;
  assign o_envelope_resync  = q.resync;
  assign o_quarter_duty     = q.duty;
  assign o_disp_data        = mif.disp_data;
endmodule

// file: nib_regs.svh
`ifndef NIB_REGS_SVH
`define NIB_REGS_SVH
// System register offsets
`define NIB_OFS_IE      5'h00
`define NIB_OFS_IRQ     5'h01
`define NIB_OFS_TAM     5'h02
`define NIB_OFS_TBM     5'h03
`define NIB_OFS_TAL     5'h04
`define NIB_OFS_TAH     5'h05
`define NIB_OFS_TBL     5'h06
`define NIB_OFS_TBH     5'h07
`define NIB_OFS_PA      5'h08
`define NIB_OFS_PB      5'h09
`define NIB_OFS_PC      5'h0A
`define NIB_OFS_PD      5'h0B
`define NIB_OFS_DET     5'h0C
`define NIB_OFS_BOND    5'h0D
`define NIB_OFS_TBR     5'h0E
`define NIB_OFS_IDX     5'h0F
`define NIB_OFS_DPL     5'h10
`define NIB_OFS_DPM     5'h11
`define NIB_OFS_DPH     5'h12
`define NIB_OFS_CTL     5'h13
`define NIB_OFS_AEC     5'h14
`define NIB_OFS_DUTY    5'h15
// Data space map
`define NIB_SYS_END     10'h020
`define NIB_DMEM_BASE   10'h020
`define NIB_DMEM_LAST   10'h11F
`define NIB_DISP_BASE   10'h300
`define NIB_DISP_LAST   10'h319
`define NIB_DISP_SLOT   9'h100
`define NIB_MEM_WORDS   282
// Reset values and codes
`define NIB_DET_ON      4'h5
`define NIB_DET_OFF     4'hA
`define NIB_CTL_RST     4'h0
`define NIB_AEC_RST     4'h0
// Control bit positions
`define NIB_CTL_PAM     0
`define NIB_CTL_HLM     1
`define NIB_CTL_OFF     2
`define NIB_CTL_OS      3
// Vectors and program store size
`define NIB_VEC_RESET   12'h000
`define NIB_VEC_EXT     12'h001
`define NIB_VEC_TA      12'h002
`define NIB_VEC_TB      12'h003
`define NIB_VEC_PORTB   12'h004
`define NIB_ROM_WORDS   2048
`endif

// file: nib_pkg.sv
package nib_pkg;
  typedef enum logic [3:0] {
    NIB_NOP  = 4'h0,
    NIB_LDA  = 4'h1,
    NIB_STA  = 4'h2,
    NIB_ADC  = 4'h3,
    NIB_ADI  = 4'h4,
    NIB_AND  = 4'h5,
    NIB_JMP  = 4'h6,
    NIB_CALL = 4'h7,
    NIB_TABLE_BRANCH_JUMP = 4'h8,
    NIB_RETURN_WITH_CONSTANT = 4'h9,
    NIB_RETURN_FROM_INTERRUPT = 4'hA,
    NIB_BC   = 4'hB
  } nib_op_e;
  typedef logic [12:0] nib_stk_t;
endpackage

// file: nib_if.sv
`timescale 1ns/1ps
interface nib_stk_if;
  logic             push;
  logic             pop;
  nib_pkg::nib_stk_t wdata;
  nib_pkg::nib_stk_t top;
  modport core (output push, output pop, output wdata, input top);
  modport stk  (input push, input pop, input wdata, output top);
endinterface

interface nib_mem_if;
  logic [9:0] addr;
  logic [3:0] wdata;
  logic       we;
  logic [3:0] rdata;
  logic [4:0] disp_addr;
  logic [3:0] disp_data;
  modport core (output addr, output wdata, output we, output disp_addr,
                input rdata, input disp_data);
  modport mem  (input addr, input wdata, input we, input disp_addr,
                output rdata, output disp_data);
endinterface

// file: nib_stack.sv
`timescale 1ns/1ps
module nib_stack (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  nib_stk_if.stk    bus
);
  typedef struct packed {
    logic [3:0][12:0] ent;
  } nib_stack_s;
  nib_stack_s q, d;

  always_comb
  begin
    d = q;
    if (bus.push)
      d.ent = {q.ent[2:0], bus.wdata};
    else if (bus.pop)
      d.ent = {q.ent[3], q.ent[3:1]};
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      q <= '0;
    else
      q <= d;
  end

  assign bus.top = q.ent[0];
endmodule

// file: nib_dmem.sv
`timescale 1ns/1ps
`include "nib_regs.svh"
module nib_dmem (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  nib_mem_if.mem    bus
);
  typedef struct packed {
    logic [3:0] disp;
  } nib_dmem_s;
  nib_dmem_s  q, d;
  logic [3:0] mem [0:`NIB_MEM_WORDS-1];
  logic [8:0] idx;
  logic       hit;
  logic [8:0] didx;

  // Data words first, display nibbles after them
  always_comb
  begin
    idx = '0;
    hit = 1'b0;
    if (bus.addr >= `NIB_DMEM_BASE && bus.addr <= `NIB_DMEM_LAST)
    begin
      idx = 9'(bus.addr - `NIB_DMEM_BASE);
      hit = 1'b1;
    end
    else if (bus.addr >= `NIB_DISP_BASE && bus.addr <= `NIB_DISP_LAST)
    begin
      idx = 9'(bus.addr - `NIB_DISP_BASE) + `NIB_DISP_SLOT;
      hit = 1'b1;
    end
    bus.rdata = hit ? mem[idx] : 4'h0;
    didx = `NIB_DISP_SLOT + {4'h0, bus.disp_addr};
    d.disp = (bus.disp_addr <= 5'(`NIB_DISP_LAST - `NIB_DISP_BASE))
           ? mem[didx] : 4'h0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (hit && bus.we)
      mem[idx] <= bus.wdata;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      q <= '0;
    else
      q <= d;
  end

  assign bus.disp_data = q.disp;
endmodule

// file: nib_core_sva.sv
`timescale 1ns/1ps
module nib_core_sva (
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_prog_we,
  input wire logic [10:0] i_prog_addr,
  input wire logic [15:0] i_prog_data,
  input wire logic [3:0]  i_irq_event,
  input wire logic [11:0] o_pc,
  input wire logic        o_detector_enable,
  input wire logic        o_alarm_pin_select,
  input wire logic        o_heavy_load_osc,
  input wire logic        o_display_off,
  input wire logic        o_seg_as_port,
  input wire logic [3:0]  o_alarm_envelope,
  input wire logic        o_envelope_resync,
  input wire logic        o_timer_a_reload,
  input wire logic        o_quarter_duty
);
  logic [15:0] rom_m [0:2047];
  logic        irq_maybe_q;
  logic [15:0] cur_w;
  logic [3:0]  cur_op;
  logic        quiet;
  logic        plain;
  logic        sta_q;
  assign cur_w = rom_m[o_pc[10:0]];
  assign cur_op = cur_w[15:12];
  assign quiet = !irq_maybe_q && (i_irq_event == 4'h0);
  assign plain = (cur_op <= 4'h5) || (cur_op >= 4'hC);
  assign sta_q = (cur_op == nib_pkg::NIB_STA);
  // Mirror of the program store
  always_ff @(posedge i_core_clk)
  begin
    if (i_prog_we)
    begin
      rom_m[i_prog_addr] <= i_prog_data;
    end
  end
  // Set once an interrupt could be pending
  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
      irq_maybe_q <= 1'b0;
    else if ((i_irq_event != 4'h0) || (sta_q && ((cur_w[9:1] == 9'h000)
             || (cur_w[9:0] == 10'h00F))))
      irq_maybe_q <= 1'b1;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  property p_reset_state;
    $rose(i_resetn) |-> o_pc == 12'h000 && o_detector_enable
      && !o_alarm_pin_select && !o_heavy_load_osc && !o_display_off
      && !o_seg_as_port && o_alarm_envelope == 4'h0 && !o_quarter_duty;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("state after reset is wrong");
  property p_step;
    quiet && plain |=> o_pc == {$past(o_pc[11]), $past(o_pc[10:0]) + 11'h001};
  endproperty
  a_step: assert property (p_step)
    else $error("program counter did not step by one");
  property p_jump;
    quiet && cur_op == nib_pkg::NIB_JMP |=> o_pc == $past(cur_w[11:0]);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target wrong");
  property p_call;
    quiet && cur_op == nib_pkg::NIB_CALL
      |=> o_pc == {$past(o_pc[11]), $past(cur_w[10:0])};
  endproperty
  a_call: assert property (p_call)
    else $error("call target or page bit wrong");
  property p_table_branch_jump;
    quiet && cur_op == nib_pkg::NIB_TABLE_BRANCH_JUMP |=> o_pc[11:8] == $past(o_pc[11:8]);
  endproperty
  a_table_branch_jump: assert property (p_table_branch_jump)
    else $error("table jump changed upper counter bits");
  property p_resync;
    o_envelope_resync || $changed(o_alarm_envelope)
      |-> $past(sta_q) && $past(cur_w[9:0]) == 10'h014 && o_envelope_resync;
  endproperty
  a_resync: assert property (p_resync)
    else $error("envelope resync not tied to its write");
  property p_reload;
    o_timer_a_reload |-> $past(sta_q) && $past(cur_w[9:0]) == 10'h005;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload pulse without high nibble write");
  property p_detector;
    $changed(o_detector_enable) |-> $past(sta_q)
      && $past(cur_w[9:0]) == 10'h00C;
  endproperty
  a_detector: assert property (p_detector)
    else $error("detector enable changed without a write");
  property p_control;
    $changed({o_seg_as_port, o_display_off, o_heavy_load_osc,
      o_alarm_pin_select}) |-> $past(sta_q) && $past(cur_w[9:0]) == 10'h013;
  endproperty
  a_control: assert property (p_control)
    else $error("control bit changed without a write");
endmodule

bind nib_core nib_core_sva nib_core_sva_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_prog_we(i_prog_we),
  .i_prog_addr(i_prog_addr), .i_prog_data(i_prog_data),
  .i_irq_event(i_irq_event), .o_pc(o_pc),
  .o_detector_enable(o_detector_enable),
  .o_alarm_pin_select(o_alarm_pin_select),
  .o_heavy_load_osc(o_heavy_load_osc), .o_display_off(o_display_off),
  .o_seg_as_port(o_seg_as_port), .o_alarm_envelope(o_alarm_envelope),
  .o_envelope_resync(o_envelope_resync),
  .o_timer_a_reload(o_timer_a_reload), .o_quarter_duty(o_quarter_duty));

// file: testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  logic        clk;
  logic        rstn;
  logic        we;
  logic [10:0] pa;
  logic [15:0] pd;
  logic [3:0]  irq;
  logic [1:0]  bond;
  logic [11:0] pc;
  logic [3:0]  pta, ptb, ptc, ptd, env;
  logic [2:0]  mda, mdb;
  logic [7:0]  lda;
  logic [7:0]  tbc;
  logic [4:0]  dsp;
  logic [3:0]  dsd;
  logic        det, alarm_pin_select, heavy_load_osc, off, os, duty;
  logic [15:0] rom [0:2047];
  logic [10:0] cur;
  int          errors;
  int          comparisons;
  nib_core nib_core_i (
    .i_core_clk(clk), .i_resetn(rstn), .i_prog_we(we), .i_prog_addr(pa),
    .i_prog_data(pd), .i_irq_event(irq), .i_port_a(4'hE),
    .i_port_b(4'h0), .i_port_c(4'h0), .i_port_d(4'h0), .i_bond_pins(bond),
    .i_timer_a_count(8'h9C), .i_timer_b_count(tbc), .i_disp_addr(dsp),
    .o_pc(pc), .o_port_a(pta), .o_port_b(ptb), .o_port_c(ptc),
    .o_port_d(ptd), .o_timer_a_mode(mda), .o_timer_b_mode(mdb),
    .o_timer_a_load(lda), .o_timer_b_load(), .o_timer_a_reload(),
    .o_timer_b_reload(), .o_detector_enable(det), .o_alarm_pin_select(alarm_pin_select),
    .o_heavy_load_osc(heavy_load_osc), .o_display_off(off), .o_seg_as_port(os),
    .o_alarm_envelope(env), .o_envelope_resync(), .o_quarter_duty(duty),
    .o_disp_data(dsd));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task give_verdict;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task at(input logic [10:0] a);
    foreach (rom[k]) rom[k] = 16'h0000;
    cur = a;
  endtask
  task w(input nib_pkg::nib_op_e o, input logic [11:0] v);
    rom[cur] = {o, v};
    cur = cur + 11'h001;
  endtask
  // Load the store under reset, release, run n cycles
  task go(input int n);
    @(negedge clk);
    rstn = 1'b0;
    for (int a = 0; a < 2048; a++)
    begin
      @(negedge clk);
      we = 1'b1;
      pa = a[10:0];
      pd = rom[a];
    end
    @(negedge clk);
    we = 1'b0;
    @(negedge clk);
    rstn = 1'b1;
    repeat (n) @(negedge clk);
  endtask
  task test_regs;
    at(11'h000);
    w(nib_pkg::NIB_ADI, 12'h005);
    w(nib_pkg::NIB_STA, 12'h014);
    w(nib_pkg::NIB_ADI, 12'h009);
    w(nib_pkg::NIB_STA, 12'h013);
    w(nib_pkg::NIB_ADI, 12'h009);
    w(nib_pkg::NIB_STA, 12'h00C);
    w(nib_pkg::NIB_ADI, 12'h003);
    w(nib_pkg::NIB_STA, 12'h00C);
    w(nib_pkg::NIB_LDA, 12'h00D);
    w(nib_pkg::NIB_STA, 12'h008);
    w(nib_pkg::NIB_LDA, 12'h005);
    w(nib_pkg::NIB_STA, 12'h009);
    w(nib_pkg::NIB_LDA, 12'h004);
    w(nib_pkg::NIB_STA, 12'h00A);
    w(nib_pkg::NIB_LDA, 12'h008);
    w(nib_pkg::NIB_STA, 12'h002);
    w(nib_pkg::NIB_STA, 12'h016);
    w(nib_pkg::NIB_LDA, 12'h016);
    w(nib_pkg::NIB_STA, 12'h00B);
    w(nib_pkg::NIB_ADI, 12'h001);
    w(nib_pkg::NIB_STA, 12'h015);
    w(nib_pkg::NIB_STA, 12'h005);
    w(nib_pkg::NIB_JMP, 12'h016);
    go(0);
    `CHK({det, os, off, heavy_load_osc, alarm_pin_select, env, duty}, 10'h200)
    repeat (6) @(negedge clk);
    `CHK({det, env}, 5'h15)
    repeat (30) @(negedge clk);
    `CHK({os, off, heavy_load_osc, alarm_pin_select}, 4'hE)
    `CHK(det, 1'b0)
    `CHK(pta, {2'b00, bond})
    `CHK({ptb, ptc}, 8'h9C)
    `CHK(mda, 3'h6)
    `CHK(ptd, 4'h0)
    `CHK({duty, lda[7:4]}, 5'h11)
    $display("test_regs done");
  endtask
  task test_flow;
    at(11'h000);
    w(nib_pkg::NIB_JMP, 12'h810);
    cur = 11'h010;
    w(nib_pkg::NIB_ADI, 12'h00F);
    w(nib_pkg::NIB_ADI, 12'h001);
    w(nib_pkg::NIB_CALL, 12'h020);
    w(nib_pkg::NIB_BC, 12'h030);
    w(nib_pkg::NIB_JMP, 12'h814);
    cur = 11'h020;
    w(nib_pkg::NIB_ADI, 12'h00F);
    w(nib_pkg::NIB_RETURN_FROM_INTERRUPT, 12'h000);
    cur = 11'h030;
    w(nib_pkg::NIB_CALL, 12'h040);
    w(nib_pkg::NIB_TABLE_BRANCH_JUMP, 12'h000);
    cur = 11'h035;
    w(nib_pkg::NIB_STA, 12'h008);
    w(nib_pkg::NIB_BC, 12'h038);
    w(nib_pkg::NIB_JMP, 12'h837);
    w(nib_pkg::NIB_JMP, 12'h838);
    cur = 11'h040;
    w(nib_pkg::NIB_RETURN_WITH_CONSTANT, 12'h035);
    go(20);
    `CHK(pc, 12'h838)
    `CHK(pta, 4'h5)
    $display("test_flow done");
  endtask
  task test_irq;
    at(11'h000);
    w(nib_pkg::NIB_JMP, 12'h010);
    w(nib_pkg::NIB_JMP, 12'h060);
    w(nib_pkg::NIB_JMP, 12'h050);
    cur = 11'h010;
    w(nib_pkg::NIB_ADI, 12'h00F);
    w(nib_pkg::NIB_STA, 12'h00A);
    w(nib_pkg::NIB_STA, 12'h000);
    w(nib_pkg::NIB_JMP, 12'h013);
    cur = 11'h060;
    w(nib_pkg::NIB_LDA, 12'h000);
    w(nib_pkg::NIB_STA, 12'h00A);
    w(nib_pkg::NIB_JMP, 12'h062);
    go(6);
    irq = 4'hC;
    @(negedge clk);
    irq = 4'h0;
    repeat (12) @(negedge clk);
    `CHK(pc, 12'h062)
    `CHK(ptc, 4'h0)
    $display("test_irq done");
  endtask
  task test_stack;
    at(11'h000);
    w(nib_pkg::NIB_JMP, 12'h010);
    for (int k = 1; k <= 5; k++)
    begin
      cur = 11'(16 * k);
      w(nib_pkg::NIB_CALL, 12'(16 * k + 16));
      w(k == 1 ? nib_pkg::NIB_JMP : nib_pkg::NIB_RETURN_WITH_CONSTANT, 12'h011);
    end
    cur = 11'h060;
    w(nib_pkg::NIB_RETURN_WITH_CONSTANT, 12'h000);
    go(25);
    `CHK(pc, 12'h021)
    $display("test_stack done");
  endtask
  task test_mem;
    at(11'h000);
    w(nib_pkg::NIB_ADI, 12'h007);
    w(nib_pkg::NIB_STA, 12'h300);
    w(nib_pkg::NIB_ADI, 12'h002);
    w(nib_pkg::NIB_STA, 12'h319);
    w(nib_pkg::NIB_STA, 12'h010);
    w(nib_pkg::NIB_ADI, 12'h009);
    w(nib_pkg::NIB_STA, 12'h011);
    w(nib_pkg::NIB_ADI, 12'h004);
    w(nib_pkg::NIB_STA, 12'h00F);
    w(nib_pkg::NIB_LDA, 12'h007);
    w(nib_pkg::NIB_STA, 12'h00B);
    w(nib_pkg::NIB_LDA, 12'h029);
    w(nib_pkg::NIB_STA, 12'h008);
    w(nib_pkg::NIB_STA, 12'h003);
    w(nib_pkg::NIB_JMP, 12'h00E);
    go(20);
    `CHK(pta, 4'h6)
    `CHK(ptd, tbc[7:4])
    `CHK(mdb, 3'h6)
    `CHK(dsd, 4'h7)
    dsp = 5'h19;
    @(negedge clk);
    `CHK(dsd, 4'h9)
    dsp = 5'h00;
    $display("test_mem done");
  endtask
  initial
  begin
    errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    we = 1'b0;
    pa = 11'h000;
    pd = 16'h0000;
    irq = 4'h0;
    bond = 2'b01;
    tbc = 8'hA5;
    dsp = 5'h00;
    repeat (2) @(negedge clk);
    test_regs();
    test_flow();
    test_irq();
    test_stack();
    test_mem();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
